// ---- rtl/cca_pkg.sv ----
// Purpose: shared constants and types for coprocessor channel arbitration
// Assumes: one channel clock at 25 MHz
// Notes: times are kept in ns, cycle counts derived here
package cca_pkg;
  // ============================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int REREQ_GAP_NS = 250;
  // least time rounds up
  localparam int REREQ_GAP_CYC = (REREQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W = 4;
  localparam logic [GAP_W-1:0] REREQ_GAP_CNT = GAP_W'(REREQ_GAP_CYC);
  // ============================================================
  // requester indices on the channel
  localparam int NUM_DMA = 7;
  localparam logic [3:0] OWNER_NONE = 4'hF;
  localparam logic [3:0] OWNER_PROC = 4'hE;
  localparam logic [3:0] OWNER_COPROC = 4'h8;
  // ============================================================
  // arbiter states
  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_OTHER = 2'b01,
    ARB_COPROC = 2'b10,
    ARB_YIELD = 2'b11
  } cca_arb_type;
  // coprocessor states
  typedef enum logic [2:0] {
    CP_IDLE = 3'b000,
    CP_REQ = 3'b001,
    CP_OWN = 3'b010,
    CP_FINISH = 3'b011,
    CP_GAP = 3'b100
  } cca_cp_type;
endpackage : cca_pkg

// ---- rtl/cca_link_if.sv ----
// Purpose: wires between the channel arbiter and the coprocessor slot
// Assumes: master is open collector, low active
// Notes: wire level of master resolved here from its enable
`timescale 1ns/1ps
interface cca_link_if;
  logic coproc_chan_request;
  logic coproc_chan_grant_n;
  logic master_n_o;
  logic master_n_oe;
  logic master_n;
  // ============================================================
  // open collector: low while driven, pulled up otherwise
  assign master_n = (master_n_oe && !master_n_o) ? 1'b0 : 1'b1;
  modport arbiter (
    input coproc_chan_request,
    output coproc_chan_grant_n,
    input master_n
  );
  modport coproc (
    output coproc_chan_request,
    input coproc_chan_grant_n,
    output master_n_o,
    output master_n_oe
  );
endinterface : cca_link_if

// ---- rtl/cca_arbiter.sv ----
// Purpose: system arbiter end, grants channel to dma, processor, coprocessor
// Assumes: other requests arrive from pins, coprocessor via the link
// Notes: coprocessor slot gives no refresh; dma 8 replaces dma 7 there
`timescale 1ns/1ps
module cca_arbiter
  import cca_pkg::*;
#(
  parameter int N_DMA = cca_pkg::NUM_DMA
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // other requesters, asynchronous pins
  input wire logic [N_DMA-1:0] DMA_REQ,
  input wire logic PROC_IO_REQ,
  input wire logic REFRESH_REQ,
  input wire logic OWNER_DONE,
  // grants to other requesters
  output logic [N_DMA-1:0] DMA_GRANT,
  output logic PROC_GRANT,
  output logic REFRESH_GRANT,
  output logic [3:0] OWNER,
  output logic SLOT_REFRESH_EN,
  // link to the coprocessor slot
  cca_link_if.arbiter LINK
);
  import cca_pkg::*;
  // ============================================================
  // synchronisers, two stages per asynchronous request and master; OWNER_DONE is sampled directly
  // master idles high; its chain resets high so no false owner follows reset
  logic [N_DMA-1:0] dma_s1_q;
  logic [N_DMA-1:0] dma_s2_q;
  logic refr_s1_q;
  logic refr_s2_q;
  logic proc_s1_q;
  logic proc_s2_q;
  logic cpreq_s1_q;
  logic cpreq_s2_q;
  logic mst_n_s1_q;
  logic mst_n_s2_q;
  logic dma_any;
  logic other_req;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      dma_s1_q <= '0;
      dma_s2_q <= '0;
      refr_s1_q <= 1'b0;
      refr_s2_q <= 1'b0;
      proc_s1_q <= 1'b0;
      proc_s2_q <= 1'b0;
      cpreq_s1_q <= 1'b0;
      cpreq_s2_q <= 1'b0;
      mst_n_s1_q <= 1'b1;
      mst_n_s2_q <= 1'b1;
    end else begin
      dma_s1_q <= DMA_REQ;
      dma_s2_q <= dma_s1_q;
      refr_s1_q <= REFRESH_REQ;
      refr_s2_q <= refr_s1_q;
      proc_s1_q <= PROC_IO_REQ;
      proc_s2_q <= proc_s1_q;
      cpreq_s1_q <= LINK.coproc_chan_request;
      cpreq_s2_q <= cpreq_s1_q;
      mst_n_s1_q <= LINK.master_n;
      mst_n_s2_q <= mst_n_s1_q;
    end
  end
  logic cp_req;
  logic cp_master;
  assign dma_any = |dma_s2_q;
  assign cp_req = cpreq_s2_q;
  assign cp_master = !mst_n_s2_q;
  // refresh, dma and processor requests outrank the coprocessor
  assign other_req = dma_any || refr_s2_q || proc_s2_q;
  // ============================================================
  // arbitration
  cca_arb_type st_q, st_d;
  logic [3:0] own_q, own_d;
  logic [N_DMA-1:0] dg_q, dg_d;
  logic pg_q, pg_d;
  logic rg_q, rg_d;
  logic gnt_n_q, gnt_n_d;
  // lowest set dma index wins
  function automatic logic [3:0] pick_dma(input logic [N_DMA-1:0] r);
    logic [3:0] idx;
    idx = OWNER_NONE;
    for (int i = N_DMA - 1; i >= 0; i--) begin
      if (r[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : pick_dma
  logic [3:0] dma_sel;
  assign dma_sel = pick_dma(dma_s2_q);
  always_comb begin
    st_d = st_q;
    own_d = own_q;
    dg_d = dg_q;
    pg_d = pg_q;
    rg_d = rg_q;
    gnt_n_d = gnt_n_q;
    unique case (st_q)
      ARB_IDLE: begin
        if (refr_s2_q) begin
          st_d = ARB_OTHER;
          own_d = OWNER_NONE;
          rg_d = 1'b1;
        end else if (dma_any) begin
          st_d = ARB_OTHER;
          own_d = dma_sel;
          dg_d = '0;
          dg_d[dma_sel[2:0]] = 1'b1;
        end else if (proc_s2_q) begin
          st_d = ARB_OTHER;
          own_d = OWNER_PROC;
          pg_d = 1'b1;
        end else if (cp_req) begin
          st_d = ARB_COPROC;
          own_d = OWNER_COPROC;
          gnt_n_d = 1'b0;
        end
      end
      ARB_OTHER: begin
        // owner must have dropped its pin one cycle before done is sampled, or it wins again
        if (OWNER_DONE) begin
          st_d = ARB_IDLE;
          own_d = OWNER_NONE;
          dg_d = '0;
          pg_d = 1'b0;
          rg_d = 1'b0;
        end
      end
      ARB_COPROC: begin
        // held across cycles while nothing else asks
        if (other_req) begin
          st_d = ARB_YIELD;
          gnt_n_d = 1'b1;
        end else if (!cp_req) begin
          st_d = ARB_IDLE;
          own_d = OWNER_NONE;
          gnt_n_d = 1'b1;
        end
      end
      ARB_YIELD: begin
        // wait for request and master to drop before handing over
        if (!cp_req && !cp_master) begin
          st_d = ARB_IDLE;
          own_d = OWNER_NONE;
        end
      end
    endcase
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st_q <= ARB_IDLE;
      own_q <= OWNER_NONE;
      dg_q <= '0;
      pg_q <= 1'b0;
      rg_q <= 1'b0;
      gnt_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      own_q <= own_d;
      dg_q <= dg_d;
      pg_q <= pg_d;
      rg_q <= rg_d;
      gnt_n_q <= gnt_n_d;
    end
  end
  // ============================================================
  // slot options
  // no refresh strobe reaches the coprocessor slot, held low from a flop
  logic slot_refr_q;
  logic slot_refr_d;
  always_comb begin
    slot_refr_d = 1'b0;
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      slot_refr_q <= 1'b0;
    end else begin
      slot_refr_q <= slot_refr_d;
    end
  end
  // ============================================================
  // outputs
  assign DMA_GRANT = dg_q;
  assign PROC_GRANT = pg_q;
  assign REFRESH_GRANT = rg_q;
  assign OWNER = own_q;
  assign SLOT_REFRESH_EN = slot_refr_q;
  assign LINK.coproc_chan_grant_n = gnt_n_q;
endmodule : cca_arbiter

// ---- rtl/cca_coproc.sv ----
// Purpose: coprocessor slot end, requests and holds the channel
// Assumes: grant arrives asynchronously on the link
// Notes: user side says when it needs the channel and when a cycle ends
`timescale 1ns/1ps
module cca_coproc
  import cca_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // user side
  input wire logic NEED_CHAN,
  input wire logic CYCLE_BUSY,
  output logic OWNS_CHAN,
  output logic DRIVE_EN,
  // link
  cca_link_if.coproc LINK
);
  import cca_pkg::*;
  // ============================================================
  // grant synchroniser
  logic g1_q;
  logic g2_q;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      g1_q <= 1'b1;
      g2_q <= 1'b1;
    end else begin
      g1_q <= LINK.coproc_chan_grant_n;
      g2_q <= g1_q;
    end
  end
  logic granted;
  assign granted = !g2_q;
  // ============================================================
  // request sequencing
  cca_cp_type st_q, st_d;
  logic req_q, req_d;
  logic mst_q, mst_d;
  logic [GAP_W-1:0] gap_q, gap_d;
  always_comb begin
    st_d = st_q;
    req_d = req_q;
    mst_d = mst_q;
    gap_d = gap_q;
    unique case (st_q)
      CP_IDLE: begin
        if (NEED_CHAN) begin
          st_d = CP_REQ;
          req_d = 1'b1;
        end
      end
      CP_REQ: begin
        if (granted) begin
          st_d = CP_OWN;
          mst_d = 1'b1;
        end else if (!NEED_CHAN) begin
          st_d = CP_GAP;
          req_d = 1'b0;
          gap_d = REREQ_GAP_CNT;
        end
      end
      CP_OWN: begin
        if (!granted) begin
          st_d = CP_FINISH;
        end else if (!NEED_CHAN && !CYCLE_BUSY) begin
          st_d = CP_GAP;
          req_d = 1'b0;
          mst_d = 1'b0;
          gap_d = REREQ_GAP_CNT;
        end
      end
      CP_FINISH: begin
        // current cycle may complete before letting go
        if (!CYCLE_BUSY) begin
          st_d = CP_GAP;
          req_d = 1'b0;
          mst_d = 1'b0;
          gap_d = REREQ_GAP_CNT;
        end
      end
      CP_GAP: begin
        if (gap_q > GAP_W'(1)) begin
          gap_d = gap_q - 1'b1;
        end else begin
          st_d = CP_IDLE;
          gap_d = '0;
        end
      end
      default: begin
        st_d = CP_IDLE;
        req_d = 1'b0;
        mst_d = 1'b0;
        gap_d = '0;
      end
    endcase
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st_q <= CP_IDLE;
      req_q <= 1'b0;
      mst_q <= 1'b0;
      gap_q <= '0;
    end else begin
      st_q <= st_d;
      req_q <= req_d;
      mst_q <= mst_d;
      gap_q <= gap_d;
    end
  end
  // ============================================================
  // outputs, drivers float whenever master is off
  assign LINK.coproc_chan_request = req_q;
  assign LINK.master_n_o = 1'b0;
  assign LINK.master_n_oe = mst_q;
  assign OWNS_CHAN = mst_q;
  assign DRIVE_EN = mst_q;
endmodule : cca_coproc

// ---- bench/cca_chk.sv ----
// Purpose: link checks between arbiter and coprocessor ends
// Assumes: one clock, sync low reset
// Notes: sees link wires only
`timescale 1ns/1ps
module cca_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // link
  input wire logic coproc_chan_request,
  input wire logic coproc_chan_grant_n,
  input wire logic master_n_o,
  input wire logic master_n_oe,
  input wire logic master_n
);
  wire req = coproc_chan_request;
  wire gnt_n = coproc_chan_grant_n;
  // ============================================================
  // properties
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // grant seen for four samples with request held
  sequence s_granted;
    $fell(gnt_n) && req ##1 (!gnt_n && req)[*3];
  endsequence
  a_reset_clear: assert property ($rose(RST_B) |-> gnt_n && !req && master_n)
    else $error("link not clear after reset");
  a_grant_needs_req: assert property ($fell(gnt_n) |-> $past(req, 3))
    else $error("grant without request");
  a_master_after_grant: assert property ($fell(master_n) |-> !$past(gnt_n, 3))
    else $error("master before grant");
  a_grant_to_master: assert property (s_granted |-> ##[0:1] !master_n)
    else $error("grant not followed by master");
  a_master_has_req: assert property (!master_n |-> req)
    else $error("master without request");
  a_regap_hold: assert property ($fell(req) |-> (!req)[*7])
    else $error("request back too soon");
  a_grant_release: assert property ($fell(req) |-> ##[1:4] gnt_n)
    else $error("grant kept after request drop");
  a_no_grant_idle: assert property ((!req)[*4] |-> gnt_n)
    else $error("grant while no request");
  a_drive_low_only: assert property (master_n_oe |-> !master_n_o)
    else $error("master driven high");
  a_float_release: assert property ($fell(master_n_oe) |-> !req && master_n)
    else $error("request kept after master release");
endmodule : cca_chk

// ---- bench/cca_tb_top.sv ----
// Purpose: both ends joined, user sides driven
// Assumes: inputs change at falling edge
// Notes: priority loop covers each dma line and refresh
`timescale 1ns/1ps
module cca_tb_top;
  import cca_pkg::*;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [NUM_DMA-1:0] dma_req = 7'h00;
  logic proc_req = 1'h0;
  logic refr_req = 1'h0;
  logic owner_done = 1'h0;
  logic need = 1'h0;
  logic busy = 1'h0;
  logic [NUM_DMA-1:0] dma_gnt;
  logic proc_gnt;
  logic refr_gnt;
  logic [3:0] owner;
  logic slot_refr;
  logic owns;
  logic drive_en;
  int errors = 0;
  int n_compared = 0;
  int k;
  int i;
  cca_link_if i_cca_link_if ();
  wire req = i_cca_link_if.coproc_chan_request;
  wire gnt_n = i_cca_link_if.coproc_chan_grant_n;
  cca_arbiter i_cca_arbiter (.CLK(clk), .RST_B(rst_b), .DMA_REQ(dma_req), .PROC_IO_REQ(proc_req),
    .REFRESH_REQ(refr_req), .OWNER_DONE(owner_done), .DMA_GRANT(dma_gnt), .PROC_GRANT(proc_gnt),
    .REFRESH_GRANT(refr_gnt), .OWNER(owner), .SLOT_REFRESH_EN(slot_refr), .LINK(i_cca_link_if));
  cca_coproc i_cca_coproc (.CLK(clk), .RST_B(rst_b), .NEED_CHAN(need), .CYCLE_BUSY(busy),
    .OWNS_CHAN(owns), .DRIVE_EN(drive_en), .LINK(i_cca_link_if));
  cca_chk i_cca_chk (.CLK(clk), .RST_B(rst_b), .coproc_chan_request(req),
    .coproc_chan_grant_n(gnt_n), .master_n_o(i_cca_link_if.master_n_o),
    .master_n_oe(i_cca_link_if.master_n_oe), .master_n(i_cca_link_if.master_n));
  // ============================================================
  // tasks
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'h1) begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : chk
  task automatic grab();
    need = 1'h1;
    for (k = 0; k < 40 && owns !== 1'h1; k++) @(negedge clk);
  endtask : grab
  // requester withdraws first; done waits until its synchronised request has gone
  task automatic release_other();
    dma_req = 7'h00;
    proc_req = 1'h0;
    refr_req = 1'h0;
    repeat (3) @(negedge clk);
    owner_done = 1'h1;
    @(negedge clk);
    owner_done = 1'h0;
  endtask : release_other
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // ============================================================
  // clock, watchdog, tests
  initial forever #20 clk = ~clk;
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    close_out();
  end
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'h1;
    repeat (2) @(negedge clk);
    chk(slot_refr === 1'h0 && owner === OWNER_NONE, "slot refresh or owner");
    grab();
    chk(gnt_n === 1'h0 && owns === 1'h1, "no grant on idle channel");
    repeat (12) @(negedge clk);
    chk(owner === OWNER_COPROC && drive_en === 1'h1, "hold lost");
    need = 1'h0;
    for (k = 0; k < 20 && req !== 1'h0; k++) @(negedge clk);
    need = 1'h1;
    for (i = 0; i < 30 && req !== 1'h1; i++) @(negedge clk);
    chk(i >= REREQ_GAP_CYC, "re-request too soon");
    grab();
    // processor arrives mid cycle; coproc must finish first
    busy = 1'h1;
    proc_req = 1'h1;
    repeat (6) @(negedge clk);
    chk(gnt_n === 1'h1 && owns === 1'h1 && proc_gnt === 1'h0, "revoke");
    busy = 1'h0;
    for (k = 0; k < 30 && proc_gnt !== 1'h1; k++) @(negedge clk);
    chk(proc_gnt === 1'h1 && owner === OWNER_PROC && owns === 1'h0, "handover");
    release_other();
    grab();
    chk(owns === 1'h1, "coproc not regranted");
    for (i = 0; i <= NUM_DMA; i++) begin
      need = 1'h0;
      repeat (20) @(negedge clk);
      need = 1'h1;
      dma_req = (i < NUM_DMA) ? 7'h01 << i : 7'h00;
      refr_req = (i == NUM_DMA);
      for (k = 0; k < 30 && dma_gnt === 7'h00 && refr_gnt !== 1'h1; k++) @(negedge clk);
      chk(gnt_n === 1'h1 && (i < NUM_DMA ? dma_gnt === dma_req && owner === 4'(i)
        : refr_gnt === 1'h1), "rank");
      release_other();
      grab();
      chk(owns === 1'h1, "coproc not granted after other");
    end
    close_out();
  end
endmodule : cca_tb_top
